/* File: rtl/scfe_top.sv */
`timescale 1ns/1ps
`default_nettype none
module scfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  // full and empty come straight from the occupancy count
  assign in_ready_o = (count_o != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid_o = (count_o != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // storage
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end
  // pointers wrap explicitly so any depth works
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_o <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count_o <= count_o + 1'b1;
      else if (pop && !push)
        count_o <= count_o - 1'b1;
    end
  end
endmodule

module scfe_uart_tx (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [15:0] div_i,
  input wire logic start_i,
  input wire logic [7:0] data_i,
  output logic busy_o,
  output logic txd_o
);
  logic [9:0] shift;
  logic [3:0] bits;
  logic [15:0] cnt;
  // idle line is high; frame is start, eight data lsb first, one stop
  assign txd_o = busy_o ? shift[0] : 1'b1;
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      shift <= '1;
      bits <= '0;
      cnt <= '0;
      busy_o <= 1'b0;
    end
    else if (!busy_o)
    begin
      if (start_i)
      begin
        shift <= {1'b1, data_i, 1'b0};
        bits <= 4'hA;
        cnt <= div_i - 16'h0001;
        busy_o <= 1'b1;
      end
    end
    else if (cnt == '0 && bits == 4'h1 && start_i)
    begin
      // next frame starts as the stop bit ends, so equal-rate streams keep pace
      shift <= {1'b1, data_i, 1'b0};
      bits <= 4'hA;
      cnt <= div_i - 16'h0001;
    end
    else if (cnt == '0)
    begin
      shift <= {1'b1, shift[9:1]};
      bits <= bits - 4'h1;
      cnt <= div_i - 16'h0001;
      if (bits == 4'h1)
        busy_o <= 1'b0;
    end
    else
      cnt <= cnt - 16'h0001;
  end
endmodule

module scfe_top
  import scfe_pkg::*;
#(
  parameter int RX_FIFO_DEPTH = RX_DEPTH,
  parameter int ALMOST_FULL = RX_ALMOST_FULL,
  parameter int NEARLY_EMPTY = RX_NEARLY_EMPTY,
  parameter int STR_SIZE = STR_DEPTH,
  parameter int COLS = 40,
  parameter int ROWS = 16,
  parameter int unsigned ONLINE_CYCLES = ONLINE_DELAY_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [3:0] config_strap_pins_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic rts_stop_o,
  input wire logic cts_stop_i,
  output logic dbg_txd_o,
  input wire logic echo_en_i,
  output scfe_req_type req_o,
  output logic req_valid_o,
  input wire logic eng_ready_i,
  input wire logic [11:0] str_rd_addr_i,
  output logic [7:0] str_rd_data_o,
  output logic [12:0] str_len_o,
  output logic str_active_o
);
  localparam int CW = $clog2(RX_FIFO_DEPTH+1);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scfe_rx_type;
  typedef enum logic [2:0] {PS_TEXT, PS_ESC, PS_CSI, PS_STR, PS_STR_ESC} scfe_ps_type;

  // cycles per bit for a strap-selected rate, rounded to nearest
  function automatic logic [15:0] baud_div(input logic [1:0] sel);
    int unsigned rate;
    case (sel)
      2'h0: rate = BAUD_SEL0;
      2'h1: rate = BAUD_SEL1;
      2'h2: rate = BAUD_SEL2;
      default: rate = BAUD_SEL3;
    endcase
    return 16'((CLK_HZ + rate / 2) / rate);
  endfunction

  logic init_done;
  logic [1:0] cfg_baud;
  logic cfg_hw;
  logic cfg_crlf;
  logic [15:0] bit_div;
  // straps are caught once after reset; later pin changes are ignored
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      init_done <= 1'b0;
      cfg_baud <= '0;
      cfg_hw <= 1'b0;
      cfg_crlf <= 1'b0;
    end
    else if (!init_done)
    begin
      init_done <= 1'b1;
      cfg_baud <= config_strap_pins_i[STRAP_BAUD_LSB +: 2];
      cfg_hw <= config_strap_pins_i[STRAP_HWFLOW_BIT];
      cfg_crlf <= config_strap_pins_i[STRAP_CRLF_BIT];
    end
  end
  assign bit_div = baud_div(cfg_baud);

  scfe_rx_type rx_state;
  logic [15:0] rx_cnt;
  logic [2:0] rx_bits;
  logic [7:0] rx_shift;
  logic rx_discard;
  logic rx_done;
  // receiver samples mid-bit; a frame begun under RTS is thrown away
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_bits <= '0;
      rx_shift <= '0;
      rx_discard <= 1'b0;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      case (rx_state)
        RX_IDLE:
          if (init_done && !rxd_i)
          begin
            rx_cnt <= {1'b0, bit_div[15:1]};
            rx_discard <= rts_stop_o;
            rx_state <= RX_START;
          end
        RX_START:
          if (rx_cnt != '0)
            rx_cnt <= rx_cnt - 16'h0001;
          else if (!rxd_i)
          begin
            rx_cnt <= bit_div - 16'h0001;
            rx_bits <= '0;
            rx_state <= RX_DATA;
          end
          else
            rx_state <= RX_IDLE;
        RX_DATA:
          if (rx_cnt != '0)
            rx_cnt <= rx_cnt - 16'h0001;
          else
          begin
            rx_shift <= {rxd_i, rx_shift[7:1]};
            rx_bits <= rx_bits + 3'h1;
            rx_cnt <= bit_div - 16'h0001;
            if (rx_bits == 3'h7)
              rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_cnt != '0)
            rx_cnt <= rx_cnt - 16'h0001;
          else
          begin
            rx_done <= rxd_i && !rx_discard;
            rx_state <= RX_IDLE;
          end
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  logic hold_valid;
  logic [7:0] hold_byte;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [CW-1:0] fifo_count;
  logic take;
  // holding register catches the one character still in flight
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      hold_valid <= 1'b0;
      hold_byte <= '0;
    end
    else if (rx_done && (!hold_valid || fifo_in_ready))
    begin
      hold_valid <= 1'b1;
      hold_byte <= rx_shift;
    end
    else if (fifo_in_ready)
      hold_valid <= 1'b0;
  end

  scfe_fifo #(.WIDTH(8), .DEPTH(RX_FIFO_DEPTH)) rx_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(hold_valid),
    .in_data_i(hold_byte),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(!req_valid_o || eng_ready_i),
    .count_o(fifo_count)
  );
  // stop only at completely full, leaving the holding slot free
  assign rts_stop_o = cfg_hw && (fifo_count == CW'(RX_FIFO_DEPTH));

  logic online_done;
  logic [31:0] online_cnt;
  logic xoff_sent;
  logic pend_xon;
  logic pend_xoff;
  logic echo_pend;
  logic [7:0] echo_byte;
  logic main_busy;
  logic main_start;
  logic [7:0] main_data;
  // nothing new starts while the host holds CTS; frame in progress finishes
  assign main_start = init_done && !main_busy && !(cfg_hw && cts_stop_i)
    && (pend_xon || pend_xoff || echo_pend);
  assign main_data = pend_xon ? CH_XON : (pend_xoff ? CH_XOFF : echo_byte);
  // start-up announce, receive-side flow control and echo, clears before sets
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      online_done <= 1'b0;
      online_cnt <= '0;
      xoff_sent <= 1'b0;
      pend_xon <= 1'b0;
      pend_xoff <= 1'b0;
      echo_pend <= 1'b0;
      echo_byte <= '0;
    end
    else
    begin
      if (main_start && pend_xon)
        pend_xon <= 1'b0;
      else if (main_start && pend_xoff)
        pend_xoff <= 1'b0;
      else if (main_start)
        echo_pend <= 1'b0;
      if (!online_done)
      begin
        online_cnt <= online_cnt + 32'h0000_0001;
        if (online_cnt == ONLINE_CYCLES - 1)
        begin
          online_done <= 1'b1;
          pend_xon <= 1'b1;
        end
      end
      else if (!cfg_hw)
      begin
        if (!xoff_sent && fifo_count >= CW'(ALMOST_FULL))
        begin
          pend_xoff <= 1'b1;
          xoff_sent <= 1'b1;
        end
        else if (xoff_sent && fifo_count <= CW'(NEARLY_EMPTY) && !pend_xoff)
        begin
          pend_xon <= 1'b1;
          xoff_sent <= 1'b0;
        end
      end
      // only one echo byte is held; a burst while busy loses echoes
      if (rx_done && echo_en_i)
      begin
        echo_pend <= 1'b1;
        echo_byte <= rx_shift;
      end
    end
  end

  scfe_uart_tx main_tx (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .div_i(bit_div),
    .start_i(main_start),
    .data_i(main_data),
    .busy_o(main_busy),
    .txd_o(txd_o)
  );
  logic dbg_busy;
  // back-to-back starts keep every copy; a host faster than this rate loses some
  scfe_uart_tx dbg_tx (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .div_i(16'(DEBUG_DIV)),
    .start_i(rx_done),
    .data_i(rx_shift),
    .busy_o(dbg_busy),
    .txd_o(dbg_txd_o)
  );

  scfe_ps_type pstate;
  logic [7:0] b;
  logic [7:0] cur_row;
  logic [7:0] cur_col;
  logic [7:0] step_row;
  logic step_scroll;
  logic [15:0] arg_acc;
  logic arg_neg;
  logic arg_have;
  logic arg_idx;
  logic arg_px;
  logic signed [15:0] arg0;
  logic given0;
  logic signed [15:0] cur_val;
  logic is_digit;
  logic str_term;
  logic in_str;
  logic str_we;
  logic esc_stored;
  logic [12:0] str_len;
  logic [7:0] str_mem [STR_SIZE];
  assign take = fifo_out_valid && (!req_valid_o || eng_ready_i);
  assign b = fifo_out_data;
  // last row scrolls instead of moving down
  assign step_scroll = (cur_row == 8'(ROWS-1));
  assign step_row = step_scroll ? cur_row : cur_row + 8'h01;
  assign cur_val = arg_neg ? -$signed(arg_acc) : $signed(arg_acc);
  assign is_digit = (b >= 8'h30) && (b <= 8'h39);
  assign str_term = (b == CH_BSLASH) || (b == CH_STR_R);
  assign in_str = (pstate == PS_STR) || (pstate == PS_STR_ESC);
  // everything but cancel and the terminator is stored, room permitting
  assign str_we = take && in_str && (b != CH_CAN) && !(pstate == PS_STR_ESC && str_term)
    && (str_len < 13'(STR_SIZE));
  assign str_len_o = str_len;
  assign str_active_o = in_str;

  // string memory with a registered read port
  always_ff @(posedge mclk_i)
  begin
    if (str_we)
      str_mem[str_len[11:0]] <= b;
  end
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      str_rd_data_o <= '0;
    else
      str_rd_data_o <= str_mem[str_rd_addr_i];
  end

  // parser, cursor tracker and request register
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pstate <= PS_TEXT;
      cur_row <= '0;
      cur_col <= '0;
      req_o <= '0;
      req_valid_o <= 1'b0;
      arg_acc <= '0;
      arg_neg <= 1'b0;
      arg_have <= 1'b0;
      arg_idx <= 1'b0;
      arg_px <= 1'b0;
      arg0 <= '0;
      given0 <= 1'b0;
      str_len <= '0;
      esc_stored <= 1'b0;
    end
    else
    begin
      if (req_valid_o && eng_ready_i)
        req_valid_o <= 1'b0;
      if (str_we)
        str_len <= str_len + 13'h0001;
      if (take)
      begin
        req_o.ch <= b;
        req_o.scroll <= 1'b0;
        case (pstate)
          PS_TEXT:
            if (b == CH_ESC)
              pstate <= PS_ESC;
            else if (b == CH_CR)
            begin
              req_o.op <= SCFE_OP_MOVE;
              req_o.col <= '0;
              req_o.row <= cfg_crlf ? step_row : cur_row;
              req_o.scroll <= cfg_crlf && step_scroll;
              req_valid_o <= 1'b1;
              cur_col <= '0;
              if (cfg_crlf)
                cur_row <= step_row;
            end
            else if (b == CH_LF)
            begin
              req_o.op <= SCFE_OP_MOVE;
              req_o.col <= cur_col;
              req_o.row <= step_row;
              req_o.scroll <= step_scroll;
              req_valid_o <= 1'b1;
              cur_row <= step_row;
            end
            else if (b == CH_BS && cur_col != '0)
            begin
              req_o.op <= SCFE_OP_MOVE;
              req_o.col <= cur_col - 8'h01;
              req_o.row <= cur_row;
              req_valid_o <= 1'b1;
              cur_col <= cur_col - 8'h01;
            end
            else if (b == CH_FF)
            begin
              req_o.op <= SCFE_OP_CLEAR;
              req_o.col <= '0;
              req_o.row <= '0;
              req_valid_o <= 1'b1;
              cur_col <= '0;
              cur_row <= '0;
            end
            else if (b >= CH_SPACE && b <= CH_FINAL_HI)
            begin
              req_o.op <= SCFE_OP_PRINT;
              req_o.col <= cur_col;
              req_o.row <= cur_row;
              req_valid_o <= 1'b1;
              if (cur_col == 8'(COLS-1))
              begin
                cur_col <= '0;
                cur_row <= step_row;
                req_o.scroll <= step_scroll;
              end
              else
                cur_col <= cur_col + 8'h01;
            end
          PS_ESC:
            if (b == CH_CSI2)
            begin
              pstate <= PS_CSI;
              arg_acc <= '0;
              arg_neg <= 1'b0;
              arg_have <= 1'b0;
              arg_idx <= 1'b0;
              arg_px <= 1'b0;
              given0 <= 1'b0;
            end
            else if (b == CH_STR_X || b == CH_STR_Q)
            begin
              pstate <= PS_STR;
              str_len <= '0;
            end
            else
              pstate <= PS_TEXT;
          PS_CSI:
            if (is_digit && arg_acc <= ARG_LIMIT)
            begin
              arg_acc <= 16'(arg_acc * 16'd10) + {12'h000, b[3:0]};
              arg_have <= 1'b1;
            end
            else if (b == CH_LT && !arg_have && !arg_neg)
              arg_neg <= 1'b1;
            else if (b == CH_DOT)
              arg_px <= 1'b1;
            else if (b == CH_SEMI && !arg_idx)
            begin
              arg0 <= cur_val;
              given0 <= arg_have;
              arg_idx <= 1'b1;
              arg_acc <= '0;
              arg_neg <= 1'b0;
              arg_have <= 1'b0;
            end
            else if (b >= CH_FINAL_LO && b <= CH_FINAL_HI)
            begin
              req_o.op <= SCFE_OP_COMMAND;
              req_o.pixel <= arg_px;
              req_o.arg0 <= arg_idx ? arg0 : cur_val;
              req_o.arg1 <= arg_idx ? cur_val : 16'sh0000;
              req_o.given <= arg_idx ? {arg_have, given0} : {1'b0, arg_have};
              req_valid_o <= 1'b1;
              pstate <= PS_TEXT;
            end
            else
              pstate <= PS_TEXT;
          PS_STR:
            if (b == CH_CAN)
            begin
              str_len <= '0;
              pstate <= PS_TEXT;
            end
            else if (b == CH_ESC)
            begin
              esc_stored <= str_we;
              pstate <= PS_STR_ESC;
            end
          PS_STR_ESC:
            if (b == CH_CAN)
            begin
              str_len <= '0;
              pstate <= PS_TEXT;
            end
            else if (str_term)
            begin
              str_len <= str_len - {12'h000, esc_stored};
              req_o.op <= SCFE_OP_STR_DONE;
              req_valid_o <= 1'b1;
              pstate <= PS_TEXT;
            end
            else if (b == CH_ESC)
              esc_stored <= str_we;
            else
              pstate <= PS_STR;
          default:
            pstate <= PS_TEXT;
        endcase
      end
    end
  end

  a_rts_full_only: assert property (@(posedge mclk_i) disable iff (reset_i)
    rts_stop_o |-> cfg_hw && !fifo_in_ready)
    else $error("rts asserted before receive buffer full");
  a_cts_blocks_tx: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cfg_hw && cts_stop_i && !main_busy) |=> !main_busy)
    else $error("transmitter started while cts held");
  a_xoff_soft_only: assert property (@(posedge mclk_i) disable iff (reset_i)
    (main_start && !pend_xon && pend_xoff) |-> !cfg_hw && xoff_sent)
    else $error("xoff sent outside software flow");
  a_online_xon: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(online_done) |-> pend_xon)
    else $error("on-line xon not queued");
  a_straps_frozen: assert property (@(posedge mclk_i) disable iff (reset_i)
    $past(init_done) |-> $stable(cfg_baud) && $stable(cfg_hw) && $stable(cfg_crlf))
    else $error("strap configuration changed after init");
  a_bs_at_start: assert property (@(posedge mclk_i) disable iff (reset_i)
    (take && pstate == PS_TEXT && b == CH_BS && cur_col == '0) |=> !req_valid_o && cur_col == '0)
    else $error("backspace at line start had an effect");
  a_ff_home: assert property (@(posedge mclk_i) disable iff (reset_i)
    (take && pstate == PS_TEXT && b == CH_FF) |=> req_valid_o && req_o.op == SCFE_OP_CLEAR
      && cur_row == '0 && cur_col == '0)
    else $error("form feed did not clear and home");
  a_can_empties: assert property (@(posedge mclk_i) disable iff (reset_i)
    (take && in_str && b == CH_CAN) |=> str_len == '0 && pstate == PS_TEXT)
    else $error("cancel left string data");
  a_xonxoff_ignored: assert property (@(posedge mclk_i) disable iff (reset_i)
    (take && pstate == PS_TEXT && (b == CH_XON || b == CH_XOFF)) |=> !req_valid_o)
    else $error("received flow character acted on");
  a_str_capacity: assert property (@(posedge mclk_i) disable iff (reset_i)
    str_len <= 13'(STR_SIZE))
    else $error("string buffer overrun");
endmodule
`default_nettype wire

/* File: shared/scfe_pkg.sv */
`default_nettype none
package scfe_pkg;
  // system clock and fixed rates
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned DEBUG_BAUD = 115_200;
  localparam int unsigned BAUD_SEL0 = 9_600;
  localparam int unsigned BAUD_SEL1 = 19_200;
  localparam int unsigned BAUD_SEL2 = 38_400;
  localparam int unsigned BAUD_SEL3 = 115_200;
  localparam int unsigned DEBUG_DIV = (CLK_HZ + DEBUG_BAUD / 2) / DEBUG_BAUD;
  // on-line announcement delay, kept well under one second
  localparam int unsigned ONLINE_DELAY_MS = 500;
  localparam int unsigned ONLINE_DELAY_CYC = ONLINE_DELAY_MS * (CLK_HZ / 1000);
  // strap field positions
  localparam int unsigned STRAP_BAUD_LSB = 0;
  localparam int unsigned STRAP_HWFLOW_BIT = 2;
  localparam int unsigned STRAP_CRLF_BIT = 3;
  // buffer sizes and flow thresholds
  localparam int unsigned RX_DEPTH = 16;
  localparam int unsigned RX_ALMOST_FULL = 12;
  localparam int unsigned RX_NEARLY_EMPTY = 4;
  localparam int unsigned STR_DEPTH = 4096;
  // character codes
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_FF = 8'h0C;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_CAN = 8'h18;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_LT = 8'h3C;
  localparam logic [7:0] CH_FINAL_LO = 8'h40;
  localparam logic [7:0] CH_STR_Q = 8'h51;
  localparam logic [7:0] CH_STR_R = 8'h52;
  localparam logic [7:0] CH_STR_X = 8'h58;
  localparam logic [7:0] CH_CSI2 = 8'h5B;
  localparam logic [7:0] CH_BSLASH = 8'h5C;
  localparam logic [7:0] CH_FINAL_HI = 8'h7E;
  localparam logic [15:0] ARG_LIMIT = 16'h0CCB;
  typedef enum logic [2:0] {
    SCFE_OP_PRINT, SCFE_OP_MOVE, SCFE_OP_CLEAR, SCFE_OP_COMMAND, SCFE_OP_STR_DONE
  } scfe_op_type;
  // one request to the display engine
  typedef struct packed {
    scfe_op_type op;
    logic [7:0] ch;
    logic scroll;
    logic [7:0] row;
    logic [7:0] col;
    logic pixel;
    logic [1:0] given;
    logic signed [15:0] arg0;
    logic signed [15:0] arg1;
  } scfe_req_type;
endpackage
`default_nettype wire

/* File: dv/scfe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scfe_host #(
  parameter int BIT = 347
) (
  input wire logic mclk_i,
  input wire logic rts_stop_i,
  input wire logic line_i,
  output logic line_o,
  output logic [7:0] byte_o,
  output logic byte_v_o
);
  initial
  begin
    line_o = 1'b1;
    byte_o = 8'h00;
    byte_v_o = 1'b0;
  end
  // one frame, lsb first; a frame never starts while the device asks us to stop
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    while (rts_stop_i) @(posedge mclk_i);
    for (int i = 0; i < 10; i++)
    begin
      line_o <= fr[i];
      repeat (BIT) @(posedge mclk_i);
    end
  endtask
  // mid-bit sampling of what the device sends back
  always
  begin
    @(negedge line_i);
    repeat (BIT + BIT / 2) @(posedge mclk_i);
    for (int i = 0; i < 8; i++)
    begin
      byte_o[i] <= line_i;
      repeat (BIT) @(posedge mclk_i);
    end
    // one-cycle pulse per byte so the bench can count frames
    byte_v_o <= 1'b1;
    @(posedge mclk_i);
    byte_v_o <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import scfe_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic eng_ready_i = 1'b0;
  logic rxd, txd, rts, req_v;
  logic [7:0] str_d, hb, c, s;
  logic hv, dv, str_act, dbg_txd;
  logic [7:0] db;
  logic [7:0] msg[$];
  int dbg_n = 0;
  logic [12:0] str_len;
  scfe_req_type req, r;
  scfe_req_type q[$];
  int errors = 0;
  int tests_run = 0;
  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  scfe_top #(.ONLINE_CYCLES(50)) i_scfe_top (.mclk_i(mclk_i), .reset_i(reset_i),
    .config_strap_pins_i(4'h3), .rxd_i(rxd), .txd_o(txd), .rts_stop_o(rts),
    .cts_stop_i(1'b0), .dbg_txd_o(dbg_txd), .echo_en_i(1'b0), .req_o(req), .req_valid_o(req_v),
    .eng_ready_i(eng_ready_i), .str_rd_addr_i(12'h000), .str_rd_data_o(str_d),
    .str_len_o(str_len), .str_active_o(str_act));
  scfe_host u_host (.mclk_i(mclk_i), .rts_stop_i(rts), .line_i(txd), .line_o(rxd),
    .byte_o(hb), .byte_v_o(hv));
  // listener on the debug port; every received character should show up here
  scfe_host #(.BIT(DEBUG_DIV)) u_dbg (.mclk_i(mclk_i), .rts_stop_i(1'b0), .line_i(dbg_txd),
    .line_o(), .byte_o(db), .byte_v_o(dv));
  always @(posedge mclk_i)
  begin
    if (dv === 1'b1) dbg_n++;
  end
  // random engine stalls; accepted requests are queued for checking
  always @(posedge mclk_i)
  begin
    eng_ready_i <= 1'($urandom);
    if (req_v === 1'b1 && eng_ready_i === 1'b1) q.push_back(req);
  end
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic get_req(input scfe_op_type op);
    int n;
    n = 0;
    while (q.size() == 0 && n < 8000)
    begin
      @(posedge mclk_i);
      n++;
    end
    chk("req", 32'd1, 32'(q.size() != 0));
    r = (q.size() == 0) ? '0 : q.pop_front();
    chk("op", 32'(op), 32'(r.op));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog sized for about 28 frames at the fastest rate
  initial
  begin
    repeat (100000) @(posedge mclk_i);
    errors++;
    conclude();
  end
  initial
  begin
    void'($urandom(29));
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int n = 0; n < 8000 && hv !== 1'b1; n++) @(posedge mclk_i);
    chk("online", 32'(CH_XON), 32'(hb));
    $display("end online");
    for (int i = 0; i < 3; i++)
    begin
      c = 8'h21 + 8'($urandom % 94);
      u_host.send(c);
      get_req(SCFE_OP_PRINT);
      chk("ch", 32'(c), 32'(r.ch));
      chk("col", i, 32'(r.col));
    end
    u_host.send(CH_CR);
    get_req(SCFE_OP_MOVE);
    chk("cr", 32'h0, {16'h0, r.row, r.col});
    u_host.send(CH_LF);
    get_req(SCFE_OP_MOVE);
    chk("lf", 32'h100, {16'h0, r.row, r.col});
    // received XON and backspace at column zero leave no request, so clear comes next
    u_host.send(CH_XON);
    u_host.send(CH_BS);
    u_host.send(CH_FF);
    get_req(SCFE_OP_CLEAR);
    $display("end controls");
    s = 8'h61 + 8'($urandom % 26);
    msg = {CH_ESC, CH_STR_X, s, CH_BS, CH_ESC, CH_BSLASH};
    foreach (msg[k]) u_host.send(msg[k]);
    get_req(SCFE_OP_STR_DONE);
    repeat (2) @(posedge mclk_i);
    chk("len", 32'd2, 32'(str_len));
    chk("str", 32'(s), 32'(str_d));
    chk("active", 32'd0, 32'(str_act));
    // aborted string, then a negative argument command
    msg = {CH_ESC, CH_STR_Q, s, CH_CAN, CH_ESC, CH_CSI2, CH_LT, 8'h34, 8'h48};
    foreach (msg[k]) u_host.send(msg[k]);
    get_req(SCFE_OP_COMMAND);
    chk("cmd", 32'h48, 32'(r.ch));
    chk("arg", 32'(-16'sd4), 32'(r.arg0));
    chk("cancel", 32'd0, 32'(str_len));
    // let the last debug copy finish before counting
    repeat (3400) @(posedge mclk_i);
    chk("dbg last", 32'h48, 32'(db));
    chk("dbg count", 32'd23, 32'(dbg_n));
    chk("echo", 32'(CH_XON), 32'(hb));
    $display("end strings");
    conclude();
  end
endmodule
`default_nettype wire
